// ---- src/rrio_pkg.sv ----
// Purpose: shared constants and types of the remote control and status i/o block.
// Assumes: 25 MHz clock; all dedicated inputs synchronous to it.
// Notes: function slots index the input and output signal-number maps.
// How it works
// [R1] teach flag follows teach mode
// [R2] auto flag follows automatic mode
// [R3] remote flag follows remote mode
// [R4] ready only after power-on delay completes
// [R5] held permit level echoed on status
// [R6] start edge runs all slots, operating shown
// [R7] stop level on line 0 holds slots
// [R8] secondary stop acts alike, number configurable
// [R9] program reset edge clears wait, selection shown
// [R10] error shown until fault clear edge
// [R11] cycle stop edge, shown while operating
// [R12] power-off level drops drives, echoed back
// [R13] power-on edge enables drives, any shown
// [R14] held rights level grants rights, shown
// [R15] lock edge toggles lock, state shown
// [R16] evasion edge starts return, shown while active
// [R17] signal numbers map functions to lines
// [R18] E inputs act on rise, L on level
package rrio_pkg;
    localparam int NUM_W = 8;
    localparam int CLK_NS = 40;
    localparam int POWERUP_NS = 10000;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STOP_LINE = 0;

    // input function slots
    localparam int IN_PERMIT = 0;
    localparam int IN_START = 1;
    localparam int IN_HALT = 2;
    localparam int IN_HALT2 = 3;
    localparam int IN_PRESET = 4;
    localparam int IN_FCLR = 5;
    localparam int IN_CYCLE = 6;
    localparam int IN_DOFF = 7;
    localparam int IN_DON = 8;
    localparam int IN_RIGHTS = 9;
    localparam int IN_LOCK = 10;
    localparam int IN_EVADE = 11;
    localparam int N_IN = 12;

    // output function slots
    localparam int OUT_TEACH = 0;
    localparam int OUT_AUTO = 1;
    localparam int OUT_REMOTE = 2;
    localparam int OUT_READY = 3;
    localparam int OUT_PERMIT = 4;
    localparam int OUT_OPER = 5;
    localparam int OUT_WAIT = 6;
    localparam int OUT_WAIT2 = 7;
    localparam int OUT_SEL = 8;
    localparam int OUT_ERR = 9;
    localparam int OUT_CYCLE = 10;
    localparam int OUT_DOFF = 11;
    localparam int OUT_DON = 12;
    localparam int OUT_RIGHTS = 13;
    localparam int OUT_LOCK = 14;
    localparam int OUT_EVADE = 15;
    localparam int N_OUT = 16;

    typedef enum logic [1:0] {
        RRIO_TEACH = 2'b00,
        RRIO_AUTO = 2'b01,
        RRIO_REMOTE = 2'b10
    } rrio_mode_t;

    typedef enum logic [1:0] {
        RRIO_IDLE = 2'b00,
        RRIO_RUN = 2'b01,
        RRIO_HOLD = 2'b10
    } rrio_slot_t;

    typedef struct packed {
        logic en;
        logic [NUM_W-1:0] num;
    } rrio_map_t;

    typedef struct packed {
        logic [N_IN-1:0] lvl;
        logic [N_IN-1:0] rise;
    } rrio_cmd_t;

    function automatic logic rrio_hits(rrio_map_t m, int unsigned line);
        return m.en && (m.num == NUM_W'(line));
    endfunction
endpackage

// ---- src/rrio_sense.sv ----
// Purpose: picks one physical input line by signal number, gives level and rise.
// Assumes: din synchronous to clock.
// Notes: unassigned or out-of-range numbers read as inactive.
`timescale 1ns/1ps
`default_nettype none
module rrio_sense #(
    parameter int LINES = 32
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [LINES-1:0] din,
    input wire rrio_pkg::rrio_map_t map,
    output logic lvl,
    output logic rise
);
    import rrio_pkg::*;

    logic sel;
    logic lvl_ff;
    logic rise_ff;

    always_comb begin
        sel = 1'b0;
        for (int i = 0; i < LINES; i++) begin
            if (rrio_hits(map, i)) begin
                sel = din[i]; // R17
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lvl_ff <= 1'b0;
            rise_ff <= 1'b0;
        end else begin
            lvl_ff <= sel; // R18
            rise_ff <= sel & ~lvl_ff; // R18
        end
    end

    assign lvl = lvl_ff;
    assign rise = rise_ff;
endmodule
`default_nettype wire

// ---- src/rrio_core.sv ----
// Purpose: dedicated remote-control inputs and status outputs of a robot controller.
// Assumes: motion engine reports cycle ends and evasion completion by pulses.
// Notes: edge commands need ready and operation rights; start also needs remote mode.
`timescale 1ns/1ps
`default_nettype none
module rrio_core #(
    parameter int LINES = 32,
    parameter int OUT_LINES = 32,
    parameter int SLOTS = 4,
    parameter int MECHS = 1,
    parameter int POWERUP_CYCLES = rrio_pkg::POWERUP_CYC
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [LINES-1:0] din,
    input wire rrio_pkg::rrio_map_t [rrio_pkg::N_IN-1:0] in_map,
    input wire rrio_pkg::rrio_map_t [rrio_pkg::N_OUT-1:0] out_map,
    input wire rrio_pkg::rrio_mode_t mode_key,
    input wire logic fault_event,
    input wire logic [SLOTS-1:0] slot_done,
    input wire logic evade_done,
    output logic [OUT_LINES-1:0] dout,
    output logic [SLOTS-1:0] slot_run,
    output logic [MECHS-1:0] drive_enable,
    output logic motion_lock,
    output logic evade_active
);
    import rrio_pkg::*;

    localparam int CNT_W = $clog2(POWERUP_CYCLES + 1);

    if (SLOTS < 1 || MECHS < 1 || POWERUP_CYCLES < 1) begin : g_bad_size
        $error("rrio_core: counts must be at least one");
    end
    if (LINES < 1 || LINES > (1 << NUM_W) || OUT_LINES > (1 << NUM_W)) begin : g_bad_lines
        $error("rrio_core: line count exceeds signal number range");
    end

    wire rrio_cmd_t cmd;
    rrio_map_t [N_IN-1:0] eff_map;
    logic [CNT_W-1:0] pwr_cnt_ff;
    logic ready_ff;
    rrio_mode_t mode_ff;
    logic permit_ff;
    logic rights_ff;
    logic err_ff;
    logic [MECHS-1:0] servo_ff;
    logic doff_ff;
    logic lock_ff;
    logic evade_ff;
    logic cycle_ff;
    rrio_slot_t slot_ff [SLOTS];
    wire logic [SLOTS-1:0] run_vec;
    wire logic [SLOTS-1:0] hold_vec;
    wire logic [SLOTS-1:0] idle_vec;
    logic [N_OUT-1:0] st;
    logic [OUT_LINES-1:0] dout_ff;
    logic [OUT_LINES-1:0] nxt_dout;
    logic accept;
    logic halt;
    logic servo_any;
    logic start_go;
    logic preset_go;
    logic lock_go;
    logic evade_go;
    logic cycle_go;
    logic don_go;

    // stop always reads line 0; every other function uses its configured number
    always_comb begin
        eff_map = in_map; // R17
        eff_map[IN_HALT].en = 1'b1; // R7
        eff_map[IN_HALT].num = NUM_W'(STOP_LINE); // R7
    end

    for (genvar f = 0; f < N_IN; f++) begin : g_sense
        rrio_sense #(
            .LINES(LINES)
        ) u_sense (
            .clock(clock),
            .reset(reset),
            .din(din),
            .map(eff_map[f]),
            .lvl(cmd.lvl[f]),
            .rise(cmd.rise[f])
        );
    end

    // power-on delay before external signals other than the two stop levels and the power-off level are honoured
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pwr_cnt_ff <= '0;
            ready_ff <= 1'b0;
        end else if (!ready_ff) begin
            if (pwr_cnt_ff == CNT_W'(POWERUP_CYCLES - 1)) begin
                ready_ff <= 1'b1; // R4
            end else begin
                pwr_cnt_ff <= pwr_cnt_ff + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_ff <= RRIO_TEACH;
        end else if (mode_key == RRIO_AUTO || mode_key == RRIO_REMOTE) begin
            mode_ff <= mode_key;
        end else begin
            mode_ff <= RRIO_TEACH; // unused key code falls back to teach
        end
    end

    // level-class grants, held only while the input stays active
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            permit_ff <= 1'b0;
            rights_ff <= 1'b0;
            doff_ff <= 1'b0;
        end else begin
            permit_ff <= ready_ff & cmd.lvl[IN_PERMIT]; // R5
            rights_ff <= ready_ff & cmd.lvl[IN_RIGHTS]; // R14
            doff_ff <= cmd.lvl[IN_DOFF]; // R12
        end
    end

    assign accept = ready_ff & rights_ff;
    assign halt = cmd.lvl[IN_HALT] | cmd.lvl[IN_HALT2]; // R7 R8
    assign servo_any = |servo_ff;
    assign start_go = cmd.rise[IN_START] & accept & permit_ff & (mode_ff == RRIO_REMOTE)
        & ~err_ff & servo_any & ~halt & ~evade_ff; // R6
    assign preset_go = cmd.rise[IN_PRESET] & accept & ~start_go; // R9
    assign lock_go = cmd.rise[IN_LOCK] & accept & ~(|run_vec); // R15
    assign evade_go = cmd.rise[IN_EVADE] & accept & servo_any & ~(|run_vec)
        & ~err_ff & ~halt; // R16
    assign cycle_go = cmd.rise[IN_CYCLE] & accept & (|run_vec); // R11
    assign don_go = cmd.rise[IN_DON] & accept & ~cmd.lvl[IN_DOFF] & ~err_ff; // R13

    // error: a new fault wins over a clear in the same cycle
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            err_ff <= 1'b0;
        end else if (fault_event) begin
            err_ff <= 1'b1; // R10
        end else if (cmd.rise[IN_FCLR] & accept) begin
            err_ff <= 1'b0; // R10
        end
    end

    // drive power for every mechanism; off-level dominates
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            servo_ff <= '0;
        end else if (cmd.lvl[IN_DOFF]) begin
            servo_ff <= '0; // R12
        end else if (don_go) begin
            servo_ff <= '1; // R13
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lock_ff <= 1'b0;
        end else if (lock_go) begin
            lock_ff <= ~lock_ff; // R15
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            evade_ff <= 1'b0;
        end else if (halt | err_ff | ~servo_any) begin
            evade_ff <= 1'b0;
        end else if (evade_go) begin
            evade_ff <= 1'b1; // R16
        end else if (evade_done) begin
            evade_ff <= 1'b0; // R16
        end
    end

    // cycle stop lasts until no slot is running any more
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cycle_ff <= 1'b0;
        end else if (!(|run_vec)) begin
            cycle_ff <= 1'b0; // R11
        end else if (cycle_go) begin
            cycle_ff <= 1'b1; // R11
        end
    end

    // per-slot program state
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                slot_ff[s] <= RRIO_IDLE;
            end else begin
                unique case (slot_ff[s])
                    RRIO_IDLE: begin
                        if (start_go) begin
                            slot_ff[s] <= RRIO_RUN; // R6
                        end
                    end
                    RRIO_RUN: begin
                        if (halt | err_ff | ~servo_any) begin
                            slot_ff[s] <= RRIO_HOLD; // R7 R8
                        end else if (slot_done[s] & cycle_ff & ~start_go) begin
                            slot_ff[s] <= RRIO_IDLE; // R11
                        end
                    end
                    RRIO_HOLD: begin
                        if (preset_go) begin
                            slot_ff[s] <= RRIO_IDLE; // R9
                        end else if (start_go) begin
                            slot_ff[s] <= RRIO_RUN; // R6
                        end
                    end
                    default: slot_ff[s] <= RRIO_IDLE;
                endcase
            end
        end
        assign run_vec[s] = (slot_ff[s] == RRIO_RUN);
        assign hold_vec[s] = (slot_ff[s] == RRIO_HOLD);
        assign idle_vec[s] = (slot_ff[s] == RRIO_IDLE);
    end

    // status functions, all from registered state
    always_comb begin
        st = '0;
        st[OUT_TEACH] = (mode_ff == RRIO_TEACH); // R1
        st[OUT_AUTO] = (mode_ff == RRIO_AUTO); // R2
        st[OUT_REMOTE] = (mode_ff == RRIO_REMOTE); // R3
        st[OUT_READY] = ready_ff; // R4
        st[OUT_PERMIT] = permit_ff; // R5
        st[OUT_OPER] = |run_vec; // R6
        st[OUT_WAIT] = |hold_vec; // R7
        st[OUT_WAIT2] = |hold_vec; // R8
        st[OUT_SEL] = |idle_vec; // R9
        st[OUT_ERR] = err_ff; // R10
        st[OUT_CYCLE] = cycle_ff; // R11
        st[OUT_DOFF] = doff_ff; // R12
        st[OUT_DON] = servo_any; // R13
        st[OUT_RIGHTS] = rights_ff; // R14
        st[OUT_LOCK] = lock_ff; // R15
        st[OUT_EVADE] = evade_ff; // R16
    end

    // route each status function to its configured output line
    always_comb begin
        nxt_dout = '0;
        for (int j = 0; j < OUT_LINES; j++) begin
            for (int k = 0; k < N_OUT; k++) begin
                if (rrio_hits(out_map[k], j)) begin
                    nxt_dout[j] = nxt_dout[j] | st[k]; // R17
                end
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dout_ff <= '0;
        end else begin
            dout_ff <= nxt_dout;
        end
    end

    logic [SLOTS-1:0] run_out_ff;
    logic [MECHS-1:0] drive_out_ff;
    logic lock_out_ff;
    logic evade_out_ff;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            run_out_ff <= '0;
            drive_out_ff <= '0;
            lock_out_ff <= 1'b0;
            evade_out_ff <= 1'b0;
        end else begin
            run_out_ff <= run_vec;
            drive_out_ff <= servo_ff;
            lock_out_ff <= lock_ff;
            evade_out_ff <= evade_ff;
        end
    end

    assign dout = dout_ff;
    assign slot_run = run_out_ff;
    assign drive_enable = drive_out_ff;
    assign motion_lock = lock_out_ff;
    assign evade_active = evade_out_ff;

    // checks
    ready_delay_a: assert property ( // R4
        @(posedge clock) disable iff (reset)
        $rose(ready_ff) |-> $past(pwr_cnt_ff) == CNT_W'(POWERUP_CYCLES - 1))
        else $error("ready rose before the power-on count ended");

    teach_flag_a: assert property ( // R1
        @(posedge clock) disable iff (reset)
        (mode_key == RRIO_TEACH) |=> st[OUT_TEACH] && !st[OUT_AUTO] && !st[OUT_REMOTE])
        else $error("teach flag not following teach mode");

    start_run_a: assert property ( // R6
        @(posedge clock) disable iff (reset)
        start_go |=> (&run_vec) ##1 slot_run == $past(run_vec))
        else $error("start did not run every slot");

    halt_hold_a: assert property ( // R7
        @(posedge clock) disable iff (reset)
        cmd.lvl[IN_HALT] && (|run_vec) |=> !(|run_vec) && (|hold_vec))
        else $error("stop did not hold running slots");

    halt2_hold_a: assert property ( // R8
        @(posedge clock) disable iff (reset)
        cmd.lvl[IN_HALT2] |=> !(|run_vec))
        else $error("secondary stop left a slot running");

    preset_idle_a: assert property ( // R9
        @(posedge clock) disable iff (reset)
        preset_go |=> ((hold_vec & $past(hold_vec)) == '0) && (st[OUT_SEL] || !$past(|hold_vec)))
        else $error("program reset left a slot waiting");

    fault_set_a: assert property ( // R10
        @(posedge clock) disable iff (reset)
        fault_event |=> err_ff ##1 (err_ff || $past(cmd.rise[IN_FCLR] && accept)))
        else $error("fault lost or cleared too early");

    cycle_end_a: assert property ( // R11
        @(posedge clock) disable iff (reset)
        cycle_ff && !(|run_vec) |=> !cycle_ff)
        else $error("cycle stop outlived the running slots");

    drive_off_a: assert property ( // R12
        @(posedge clock) disable iff (reset)
        cmd.lvl[IN_DOFF] |=> servo_ff == '0 && doff_ff)
        else $error("power-off level did not drop drives");

    rights_grant_a: assert property ( // R14
        @(posedge clock) disable iff (reset)
        ready_ff && cmd.lvl[IN_RIGHTS] |=> rights_ff)
        else $error("held rights request not granted");

    lock_toggle_a: assert property ( // R15
        @(posedge clock) disable iff (reset)
        lock_go |=> lock_ff != $past(lock_ff))
        else $error("lock edge did not change lock state");

    start_cover_c: cover property (
        @(posedge clock) disable iff (reset) start_go ##1 (&run_vec));
    resume_cover_c: cover property (
        @(posedge clock) disable iff (reset) (|hold_vec) ##[1:50] start_go);
    evade_cover_c: cover property (
        @(posedge clock) disable iff (reset) evade_go ##[1:50] evade_done);
endmodule
`default_nettype wire

// ---- testbench/rrio_plc.sv ----
// Purpose: external sequencer model driving the dedicated input lines.
// Assumes: lines change at the falling edge only.
// Notes: edge functions get a low gap so each new rise is seen.
`timescale 1ns/1ps
`default_nettype none
module rrio_plc #(
    parameter int LINES = 32
) (
    input wire logic clock,
    output logic [LINES-1:0] din
);
    initial din = '0;
    // level functions stay as set until changed
    task automatic hold(input int line, input logic v);
        @(negedge clock);
        din[line] = v;
    endtask
    // two cycles high, two low
    task automatic pulse(input int line);
        @(negedge clock);
        din[line] = 1'b1;
        repeat (2) @(negedge clock);
        din[line] = 1'b0;
        repeat (2) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ---- testbench/test_robot_remote_io_control.sv ----
// Purpose: self-checking bench of the remote control and status i/o block.
// Assumes: power-on delay shortened to 4 cycles.
// Notes: output lines shifted by a random offset, secondary stop on a random line.
`timescale 1ns/1ps
`default_nettype none
module test_robot_remote_io_control;
    import rrio_pkg::*;
    logic clock, reset, fault_event, evade_done, motion_lock, evade_active;
    logic [31:0] din, dout;
    logic [3:0] slot_done, slot_run;
    logic [0:0] drive_enable;
    rrio_map_t [N_IN-1:0] in_map;
    rrio_map_t [N_OUT-1:0] out_map;
    rrio_mode_t mode_key;
    int mismatches, checks, off, sec;

    rrio_core #(.POWERUP_CYCLES(4)) dut (
        .clock(clock), .reset(reset), .din(din), .in_map(in_map), .out_map(out_map),
        .mode_key(mode_key), .fault_event(fault_event), .slot_done(slot_done),
        .evade_done(evade_done), .dout(dout), .slot_run(slot_run),
        .drive_enable(drive_enable), .motion_lock(motion_lock), .evade_active(evade_active)
    );
    rrio_plc plc (.clock(clock), .din(din));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    function automatic logic mode_bit(rrio_mode_t m, int j);
        case (j)
            OUT_AUTO: return m == RRIO_AUTO;
            OUT_REMOTE: return m == RRIO_REMOTE;
            default: return m != RRIO_AUTO && m != RRIO_REMOTE;
        endcase
    endfunction

    function automatic int ln(int f);
        return int'(in_map[f].num);
    endfunction

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic st(input string n, input int j, input logic e);
        chk(n, {31'h0, dout[j + off]}, {31'h0, e});
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #(40 * 5000);
        mismatches++;
        print_verdict();
    end

    initial begin
        void'($urandom(32870));
        off = $urandom_range(16, 0);
        sec = $urandom_range(31, 13);
        reset = 1'b1;
        fault_event = 1'b0;
        evade_done = 1'b0;
        slot_done = '0;
        mode_key = RRIO_TEACH;
        for (int i = 0; i < N_IN; i++) begin
            in_map[i] = '{1'b1, 8'(i + 1)};
        end
        in_map[IN_HALT2].num = 8'(sec);
        for (int j = 0; j < N_OUT; j++) begin
            out_map[j] = '{1'b1, 8'(j + off)};
        end
        step(16);
        chk("dout in reset", dout, 32'h0);
        reset = 1'b0;
        step(2);
        st("ready early", OUT_READY, 1'b0);
        st("select idle", OUT_SEL, 1'b1);
        step(8);
        st("ready", OUT_READY, 1'b1);
        for (int m = 3; m >= 0; m--) begin
            mode_key = rrio_mode_t'(m);
            step(4);
            for (int j = 0; j < 3; j++) begin
                st("mode flag", j, mode_bit(mode_key, j));
            end
        end
        plc.pulse(ln(IN_DON));
        chk("drive without rights", 32'(drive_enable), 32'h0);
        plc.hold(ln(IN_RIGHTS), 1'b1);
        plc.hold(ln(IN_PERMIT), 1'b1);
        step(4);
        st("rights", OUT_RIGHTS, 1'b1);
        st("permit", OUT_PERMIT, 1'b1);
        plc.pulse(ln(IN_DON));
        chk("drive on", 32'(drive_enable), 32'h1);
        st("drive on flag", OUT_DON, 1'b1);
        plc.hold(ln(IN_DOFF), 1'b1);
        step(4);
        chk("drive off", 32'(drive_enable), 32'h0);
        st("off echo", OUT_DOFF, 1'b1);
        plc.hold(ln(IN_DOFF), 1'b0);
        step(4);
        st("off echo gone", OUT_DOFF, 1'b0);
        plc.pulse(ln(IN_DON));
        for (int i = 0; i < 2; i++) begin
            plc.pulse(ln(IN_LOCK));
            chk("lock", 32'(motion_lock), 32'(i == 0));
            st("lock flag", OUT_LOCK, i == 0);
        end
        plc.pulse(ln(IN_EVADE));
        chk("evasion", 32'(evade_active), 32'h1);
        st("evasion flag", OUT_EVADE, 1'b1);
        @(negedge clock);
        evade_done = 1'b1;
        @(negedge clock);
        evade_done = 1'b0;
        step(3);
        chk("evasion end", 32'(evade_active), 32'h0);
        plc.pulse(ln(IN_START));
        chk("start in teach", 32'(slot_run), 32'h0);
        mode_key = RRIO_REMOTE;
        for (int k = 0; k < 2; k++) begin
            step($urandom_range(3, 1));
            plc.pulse(ln(IN_START));
            chk("slots run", 32'(slot_run), 32'hf);
            st("operating", OUT_OPER, 1'b1);
            st("select busy", OUT_SEL, 1'b0);
            plc.hold(k == 0 ? STOP_LINE : sec, 1'b1);
            step(4);
            st("wait", OUT_WAIT, 1'b1);
            st("wait two", OUT_WAIT2, 1'b1);
            st("operating held", OUT_OPER, 1'b0);
            plc.hold(k == 0 ? STOP_LINE : sec, 1'b0);
            plc.pulse(ln(IN_PRESET));
            st("wait cleared", OUT_WAIT, 1'b0);
            st("wait two cleared", OUT_WAIT2, 1'b0);
            st("select back", OUT_SEL, 1'b1);
        end
        plc.pulse(ln(IN_START));
        plc.pulse(ln(IN_CYCLE));
        st("cycle stop", OUT_CYCLE, 1'b1);
        @(negedge clock);
        slot_done = 4'hf;
        @(negedge clock);
        slot_done = 4'h0;
        step(3);
        chk("cycle end", 32'(slot_run), 32'h0);
        st("cycle flag gone", OUT_CYCLE, 1'b0);
        plc.pulse(ln(IN_START));
        @(negedge clock);
        fault_event = 1'b1;
        @(negedge clock);
        fault_event = 1'b0;
        step(3);
        st("error", OUT_ERR, 1'b1);
        chk("slots stop on error", 32'(slot_run), 32'h0);
        plc.pulse(ln(IN_FCLR));
        st("error cleared", OUT_ERR, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
